// ---- rtl/psr_pkg.sv ----
// How it works
// RQ1: select low copies all eight parallel inputs into the stages, no clock edge needed.
// RQ2: select high captures serial input into first stage on effective clock rising edge.
// RQ3: each shift edge moves contents one stage toward the last stage, except an edge that comes while the output queue is full.
// RQ4: both clock inputs behave identically; swapping them changes nothing.
// RQ5: either clock input held high inhibits edges on the other input.
// RQ6: controller should raise inhibit only while the other clock is high.
// RQ7: contents hold indefinitely; any clock rate down to zero is accepted.
// RQ8: last stage drives true output and its complement at all times.
// RQ9: last parallel input loads final stage, reaching both outputs during load.
// RQ10: parallel inputs map in order, first input to first stage, last to output stage.
// RQ11: clock edges are ignored while select is low; load beats shift.
package psr_pkg;
	localparam int STAGES = 8;
	localparam int LAST = STAGES - 1;
	localparam logic [STAGES-1:0] STAGE_RESET = 8'h00;
	localparam int FIFO_WIDTH = 1;
	localparam int FIFO_DEPTH = 8;
	typedef enum logic [1:0] {
		PSR_LOAD = 2'h1,
		PSR_SHIFT = 2'h2
	} psr_mode_t;
endpackage

// ---- rtl/psr_fifo.sv ----
`timescale 1ns/1ps
module psr_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 8
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// registered read data: refresh whenever the head changes
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			out_data <= '0;
			out_valid <= 1'b0;
		end else if (!out_valid || out_ready) begin
			if (count != '0 && !(out_valid && count == (AW+1)'(1))) begin
				out_data <= mem[out_valid ? ((rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1)
					: rd_ptr];
				out_valid <= 1'b1;
			end else begin
				out_valid <= 1'b0;
			end
		end
	end

	assign in_ready = (count != (AW+1)'(DEPTH));
endmodule

// ---- rtl/psr_shift_reg.sv ----
`timescale 1ns/1ps
module psr_shift_reg
	import psr_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic load_shift_n,
	input wire logic clk_a,
	input wire logic clk_b,
	input wire logic serial_data_in,
	input wire logic [psr_pkg::STAGES-1:0] par_in,
	output logic last_q,
	output logic last_q_n,
	output logic serial_valid,
	input wire logic serial_ready,
	output logic serial_bit,
	output logic in_stall
);
	import psr_pkg::*;

	psr_mode_t mode;
	logic [STAGES-1:0] stage;
	logic clk_a_d;
	logic clk_b_d;
	logic shift_edge;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_data;

	// effective clock is the OR of both inputs: a rise of one counts only if the other is low
	function automatic logic eff_rise(input logic a_now, input logic a_old, input logic b_now,
		input logic b_old);
		eff_rise = (a_now || b_now) && !(a_old || b_old);
	endfunction

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			clk_a_d <= 1'b0;
			clk_b_d <= 1'b0;
		end else begin
			clk_a_d <= clk_a;
			clk_b_d <= clk_b;
		end
	end

	// symmetric in a and b, and a high level on either masks the other
	assign shift_edge = eff_rise(clk_a, clk_a_d, clk_b, clk_b_d); // RQ4 RQ5

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mode <= PSR_LOAD;
		end else begin
			mode <= load_shift_n ? PSR_SHIFT : PSR_LOAD;
		end
	end

	// load is level sensitive and overrides any edge; with no edge the stages just hold
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			stage <= STAGE_RESET;
		end else if (!load_shift_n) begin
			stage <= par_in; // RQ1 RQ9 RQ10 RQ11
		end else if (shift_edge && fifo_in_ready) begin
			stage <= {stage[LAST-1:0], serial_data_in}; // RQ2 RQ3 RQ7
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			last_q <= STAGE_RESET[LAST];
			last_q_n <= ~STAGE_RESET[LAST];
		end else if (!load_shift_n) begin
			last_q <= par_in[LAST]; // RQ9
			last_q_n <= ~par_in[LAST]; // RQ9
		end else if (shift_edge && fifo_in_ready) begin
			last_q <= stage[LAST-1]; // RQ8
			last_q_n <= ~stage[LAST-1]; // RQ8
		end else begin
			last_q <= stage[LAST];
			last_q_n <= ~stage[LAST];
		end
	end

	// bits leaving the last stage are queued; a full queue stalls shifting
	psr_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.rst(rst),
		.in_data(stage[LAST]),
		.in_valid(load_shift_n && shift_edge),
		.in_ready(fifo_in_ready),
		.out_data(fifo_out_data),
		.out_valid(fifo_out_valid),
		.out_ready(serial_ready)
	);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			in_stall <= 1'b0;
		end else begin
			in_stall <= ~fifo_in_ready;
		end
	end

	assign serial_valid = fifo_out_valid;
	assign serial_bit = fifo_out_data;

	a_outs_complement: assert property (@(posedge clk_sys) disable iff (rst) // RQ8
		last_q_n == ~last_q) else $error("outputs not complementary");

	a_load_copies: assert property (@(posedge clk_sys) disable iff (rst) // RQ1
		!load_shift_n |=> stage == $past(par_in)) else $error("parallel load missed");

	a_load_out: assert property (@(posedge clk_sys) disable iff (rst) // RQ9
		!load_shift_n |=> last_q == $past(par_in[LAST])) else $error("last input not on output");

	a_shift_in: assert property (@(posedge clk_sys) disable iff (rst) // RQ2
		load_shift_n && shift_edge && fifo_in_ready |=> stage[0] == $past(serial_data_in))
		else $error("serial bit not captured");

	a_shift_move: assert property (@(posedge clk_sys) disable iff (rst) // RQ3
		load_shift_n && shift_edge && fifo_in_ready |=>
		stage[LAST:1] == $past(stage[LAST-1:0])) else $error("stages did not advance");

	a_hold_idle: assert property (@(posedge clk_sys) disable iff (rst) // RQ7
		load_shift_n && !shift_edge |=> $stable(stage)) else $error("stages changed without edge");

	a_inhibit_blocks: assert property (@(posedge clk_sys) disable iff (rst) // RQ5
		clk_b_d && clk_b && $rose(clk_a) |-> !shift_edge) else $error("inhibit ignored");

	a_load_priority: assert property (@(posedge clk_sys) disable iff (rst) // RQ11
		!load_shift_n && shift_edge |=> stage == $past(par_in)) else $error("shift beat load");

	a_swap_same: assert property (@(posedge clk_sys) disable iff (rst) // RQ4
		shift_edge == eff_rise(clk_b, clk_b_d, clk_a, clk_a_d)) else $error("clocks not symmetric");

	// cross-checks on mode, clock gating, output stage and the outbound queue
	a_mode_load: assert property ( // RQ11
		@(posedge clk_sys) disable iff (rst)
		!load_shift_n |=> mode == PSR_LOAD)
		else $error("mode not load");

	a_mode_shift: assert property ( // RQ2
		@(posedge clk_sys) disable iff (rst)
		load_shift_n |=> mode == PSR_SHIFT)
		else $error("mode not shift");

	a_inhibit_by_a: assert property ( // RQ5
		@(posedge clk_sys) disable iff (rst)
		clk_a_d && clk_a && $rose(clk_b) |-> !shift_edge)
		else $error("inhibit on a ignored");

	a_rise_a_alone: assert property ( // RQ4
		@(posedge clk_sys) disable iff (rst)
		!clk_a_d && clk_a && !clk_b_d && !clk_b |-> shift_edge)
		else $error("rise on a missed");

	a_rise_b_alone: assert property ( // RQ4
		@(posedge clk_sys) disable iff (rst)
		!clk_b_d && clk_b && !clk_a_d && !clk_a |-> shift_edge)
		else $error("rise on b missed");

	a_clk_a_track: assert property ( // RQ4
		@(posedge clk_sys) disable iff (rst)
		1'b1 |=> clk_a_d == $past(clk_a))
		else $error("clock a history lost");

	a_clk_b_track: assert property ( // RQ4
		@(posedge clk_sys) disable iff (rst)
		1'b1 |=> clk_b_d == $past(clk_b))
		else $error("clock b history lost");

	a_inhibit_hold: assert property ( // RQ5
		@(posedge clk_sys) disable iff (rst)
		load_shift_n && clk_b_d && clk_b |=> $stable(stage))
		else $error("shift while inhibited");

	a_out_is_last: assert property ( // RQ8
		@(posedge clk_sys) disable iff (rst)
		last_q == stage[LAST])
		else $error("output not last stage");

	a_out_follow: assert property ( // RQ7
		@(posedge clk_sys) disable iff (rst)
		load_shift_n && !shift_edge |=> last_q == $past(stage[LAST]))
		else $error("output moved while idle");

	a_shift_out: assert property ( // RQ3
		@(posedge clk_sys) disable iff (rst)
		load_shift_n && shift_edge && fifo_in_ready |=> last_q == $past(stage[LAST-1]))
		else $error("output did not advance");

	a_stall_drop: assert property ( // RQ3
		@(posedge clk_sys) disable iff (rst)
		load_shift_n && shift_edge && !fifo_in_ready |=> $stable(stage))
		else $error("shift taken while full");

	a_stall_hold_q: assert property ( // RQ7
		@(posedge clk_sys) disable iff (rst)
		load_shift_n && !fifo_in_ready |=> $stable(last_q))
		else $error("output moved while full");

	a_single_edge: assert property ( // RQ3
		@(posedge clk_sys) disable iff (rst)
		shift_edge |=> !shift_edge)
		else $error("double shift edge");

	a_stall_reg: assert property ( // RQ3
		@(posedge clk_sys) disable iff (rst)
		1'b1 |=> in_stall == $past(!fifo_in_ready))
		else $error("stall flag wrong");

	a_empty_no_stall: assert property ( // RQ3
		@(posedge clk_sys) disable iff (rst)
		!serial_valid |=> !in_stall)
		else $error("stall with empty queue");

	a_serial_keep: assert property ( // RQ3
		@(posedge clk_sys) disable iff (rst)
		serial_valid && !serial_ready |=> serial_valid && $stable(serial_bit))
		else $error("queue head dropped");

	a_reset_state: assert property ( // RQ8
		@(posedge clk_sys)
		rst |=> !last_q && last_q_n && !in_stall && !serial_valid)
		else $error("reset state wrong");
endmodule

// ---- tb/psr_ctrl_model.sv ----
`timescale 1ns/1ps
module psr_ctrl_model (
	input wire logic clk_sys,
	output logic load_shift_n,
	output logic clk_a,
	output logic clk_b,
	output logic serial_data_in,
	output logic [7:0] par_in
);
	initial {load_shift_n, clk_a, clk_b, serial_data_in, par_in} = 12'h800;
	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic pulse(input logic use_b, input logic inh, input logic d);
		wt(1);
		serial_data_in = d;
		if (use_b) clk_b = 1'b1; else clk_a = 1'b1;
		wt(2);
		if (inh) begin
			// b rises only while a is high, so no second edge
			clk_b = 1'b1;
			wt(2);
			clk_a = 1'b0;
			wt(2);
			clk_a = 1'b1;
			wt(2);
		end
		{clk_a, clk_b} = 2'h0;
		wt(2);
	endtask
	task automatic load(input logic [7:0] v);
		wt(1);
		par_in = v;
		load_shift_n = 1'b0;
		wt(2);
		// clock rises mid-load and is still high at release
		clk_a = 1'b1;
		wt(2);
		load_shift_n = 1'b1;
		wt(2);
		clk_a = 1'b0;
		wt(2);
	endtask
endmodule

// ---- tb/psr_shift_reg_tb.sv ----
`timescale 1ns/1ps
module psr_shift_reg_tb;
	import psr_pkg::*;
	logic clk_sys, rst, load_shift_n, clk_a, clk_b, serial_data_in, serial_ready;
	logic [STAGES-1:0] par_in, m;
	logic last_q, last_q_n, serial_valid, serial_bit, in_stall;
	int fails, n_compared;
	logic gq[$], eq[$];
	psr_shift_reg i_psr_shift_reg (.clk_sys(clk_sys), .rst(rst), .load_shift_n(load_shift_n),
		.clk_a(clk_a), .clk_b(clk_b), .serial_data_in(serial_data_in), .par_in(par_in),
		.last_q(last_q), .last_q_n(last_q_n), .serial_valid(serial_valid),
		.serial_ready(serial_ready), .serial_bit(serial_bit), .in_stall(in_stall));
	psr_ctrl_model i_psr_ctrl_model (.clk_sys(clk_sys), .load_shift_n(load_shift_n),
		.clk_a(clk_a), .clk_b(clk_b), .serial_data_in(serial_data_in), .par_in(par_in));
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) if (serial_valid === 1'b1 && serial_ready) gq.push_back(serial_bit);
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		$display("errors=%0d compared=%0d", fails, n_compared);
		if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic sh(input logic b, input logic inh, input logic d, input logic take);
		i_psr_ctrl_model.pulse(b, inh, d);
		if (take) begin
			eq.push_back(m[LAST]);
			m = {m[LAST-1:0], d};
		end
		chk({last_q, last_q_n}, {m[LAST], ~m[LAST]});
	endtask
	task automatic ld(input logic [7:0] v);
		i_psr_ctrl_model.load(v);
		m = v;
		chk({last_q, last_q_n}, {v[7], ~v[7]});
	endtask
	task automatic t_shift;
		ld(8'ha5);
		for (int k = 0; k < 12; k++) sh(k[1], 1'b0, k[0], 1'b1);
	endtask
	task automatic t_inhibit;
		ld(8'h40);
		sh(1'b0, 1'b1, 1'b1, 1'b1);
	endtask
	task automatic t_hold;
		ld(8'h81);
		repeat (40) @(posedge clk_sys);
		#1;
		chk({last_q, last_q_n}, 8'h2);
	endtask
	task automatic t_full;
		serial_ready = 1'b0;
		for (int k = 0; k < 8; k++) sh(1'b0, 1'b0, 1'b1, 1'b1);
		// fifo full: this edge must be dropped
		sh(1'b0, 1'b0, 1'b0, 1'b0);
		chk(in_stall, 8'h1);
		serial_ready = 1'b1;
		repeat (20) @(posedge clk_sys);
		#1;
		chk(8'(gq.size()), 8'(eq.size()));
		foreach (eq[i]) chk(gq[i], eq[i]);
	endtask
	initial begin
		rst = 1'b1;
		serial_ready = 1'b1;
		fails = 0;
		n_compared = 0;
		m = '0;
		repeat (8) @(posedge clk_sys);
		#1 rst = 1'b0;
		chk({last_q, last_q_n}, 8'h1);
		t_shift();
		t_inhibit();
		t_hold();
		t_full();
		end_sim();
	end
	initial begin
		#20us;
		fails++;
		end_sim();
	end
endmodule
